// File: src/swdt_top.v
`timescale 1ns/1ns
`include "swdt_consts.vh"
// supervision_timer: watchdog with register port, dependent/independent modes
module swdt_top #(
    parameter CW         = 32,
    parameter TIME_SCALE = 1,
    parameter [CW-1:0] RST_PULSE_CYC = 32'd500
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // register port
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // system state
    input  wire       independent_mode_select,
    input  wire       boot_done,
    input  wire       seq_done,
    input  wire       seq_reset_n,
    // host
    input  wire       host_activity_in,
    output reg        timeout_flag_out_n,
    output wire       wd_reset_out_n,
    // status
    output wire       wd_active,
    output wire       in_startup
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_STRT = 4'b0010;
    localparam [3:0] ST_RUN  = 4'b0100;
    localparam [3:0] ST_EXP  = 4'b1000;

    reg [7:0]    cfg_q;
    reg [3:0]    st_q;
    reg [3:0]    st_d;
    reg [CW-1:0] cnt_q;
    reg [CW-1:0] cnt_d;
    reg [1:0]    flag_cnt_q;
    reg [1:0]    flag_cnt_d;
    reg          flag_q;
    reg          flag_d;
    reg [CW-1:0] rst_cnt_q;
    reg [CW-1:0] rst_cnt_d;

    wire          toggle;
    wire [CW-1:0] to_cyc;
    wire [CW-1:0] sd_cyc;
    wire          en       = cfg_q[`SWDT_BIT_EN];
    wire          sd_en    = cfg_q[`SWDT_BIT_SDEN];
    wire          rst_en   = cfg_q[`SWDT_BIT_RSTEN];
    wire          rst_busy = (rst_cnt_q != {CW{1'b0}});
    // dependent mode also watches the reset that this block itself drives
    wire          sys_rst  = !seq_reset_n || rst_busy;
    wire          allowed  = independent_mode_select ? boot_done
                                                     : (seq_done && !sys_rst);
    wire          hold     = !en || !allowed;
    wire [CW-1:0] to_lim   = to_cyc / TIME_SCALE;
    wire [CW-1:0] sd_lim   = sd_cyc / TIME_SCALE;

    swdt_edge_det u_edge (
        .clk              (clk),
        .rst_b            (rst_b),
        .host_activity_in (host_activity_in),
        .toggle_pulse     (toggle)
    );

    swdt_period_sel #(.CW(CW)) u_sel (
        .to_code   (cfg_q[`SWDT_TO_MSB:`SWDT_TO_LSB]),
        .sd_code   (cfg_q[`SWDT_SD_MSB:`SWDT_SD_LSB]),
        .to_cycles (to_cyc),
        .sd_cycles (sd_cyc)
    );

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= `SWDT_CFG_RESET;
        end else if (reg_wr && reg_addr == `SWDT_REG_CFG) begin
            cfg_q <= reg_wdata;
        end
    end

    always @* begin
        reg_rdata = (reg_addr == `SWDT_REG_CFG) ? cfg_q : 8'h00;
    end

    always @* begin
        st_d       = st_q;
        cnt_d      = cnt_q;
        flag_d     = flag_q;
        flag_cnt_d = flag_cnt_q;
        rst_cnt_d  = rst_busy ? rst_cnt_q - {{CW-1{1'b0}}, 1'b1} : rst_cnt_q;
        case (st_q)
            ST_IDLE: begin
                flag_d = 1'b0;
                cnt_d  = {CW{1'b0}};
                if (!hold) begin
                    st_d = sd_en ? ST_STRT : ST_RUN;
                end
            end
            ST_STRT: begin
                if (toggle) begin
                    st_d  = ST_RUN;
                    cnt_d = {CW{1'b0}};
                end else if (cnt_q + {{CW-1{1'b0}}, 1'b1} >= sd_lim) begin
                    st_d   = ST_EXP;
                    flag_d = 1'b1;
                    cnt_d  = {CW{1'b0}};
                end else begin
                    cnt_d = cnt_q + {{CW-1{1'b0}}, 1'b1};
                end
            end
            ST_RUN: begin
                if (toggle) begin
                    cnt_d = {CW{1'b0}};
                end else if (cnt_q + {{CW-1{1'b0}}, 1'b1} >= to_lim) begin
                    st_d   = ST_EXP;
                    flag_d = 1'b1;
                    cnt_d  = {CW{1'b0}};
                end else begin
                    cnt_d = cnt_q + {{CW-1{1'b0}}, 1'b1};
                end
            end
            ST_EXP: begin
                if (rst_en) begin
                    flag_cnt_d = flag_cnt_q + 2'h1;
                    if (flag_cnt_q == 2'h0) begin
                        rst_cnt_d = RST_PULSE_CYC;
                    end
                    if (flag_cnt_q == (`SWDT_FLAG_CYC - 1)) begin
                        flag_d     = 1'b0;
                        flag_cnt_d = 2'h0;
                        st_d       = ST_IDLE;
                    end
                end else if (toggle) begin
                    flag_d = 1'b0;
                    st_d   = ST_RUN;
                    cnt_d  = {CW{1'b0}};
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        // the flag pulse must finish even if the reset it raised now holds the dog
        if (hold && !(st_q == ST_EXP && rst_en)) begin
            st_d       = ST_IDLE;
            cnt_d      = {CW{1'b0}};
            flag_d     = 1'b0;
            flag_cnt_d = 2'h0;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q       <= ST_IDLE;
            cnt_q      <= {CW{1'b0}};
            flag_q     <= 1'b0;
            flag_cnt_q <= 2'h0;
            rst_cnt_q  <= {CW{1'b0}};
        end else begin
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            flag_q     <= flag_d;
            flag_cnt_q <= flag_cnt_d;
            rst_cnt_q  <= rst_cnt_d;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timeout_flag_out_n <= 1'b1;
        end else begin
            timeout_flag_out_n <= !flag_d;
        end
    end

    assign wd_reset_out_n = !rst_busy;
    assign wd_active      = (st_q != ST_IDLE);
    assign in_startup     = (st_q == ST_STRT);
endmodule // swdt_top

// File: src/swdt_consts.vh
// Contract
// - timeout code bits 2:0 select period
// - startup delay code bits 4:3
// - bit 5 enables the watchdog
// - bit 6 adds long startup delay
// - bit 7 lets expiry drive reset
// - mode bit one selects independent mode
// - independent: start after lockout and boot
// - independent: sequencer reset leaves watchdog alone
// - flag asserts, then reset, then flag releases
// - flag low three clocks when reset enabled
// - reset disabled: flag only, reset untouched
// - dependent: idle and cleared while reset asserted, once any running flag pulse ends
// - toggle each period, else flag until toggle
// - first toggle ends startup delay
// - expiry pulses reset for reset timeout
`ifndef SWDT_CONSTS_VH
`define SWDT_CONSTS_VH

`define SWDT_REG_CFG        8'h55
`define SWDT_CFG_RESET      8'h00
`define SWDT_TO_MSB         2
`define SWDT_TO_LSB         0
`define SWDT_SD_MSB         4
`define SWDT_SD_LSB         3
`define SWDT_BIT_EN         5
`define SWDT_BIT_SDEN       6
`define SWDT_BIT_RSTEN      7

// clock rate and timeout periods in microseconds
`define SWDT_CLK_HZ         20000000
`define SWDT_TO0_US         1000
`define SWDT_TO1_US         4000
`define SWDT_TO2_US         12500
`define SWDT_TO3_US         50000
`define SWDT_TO4_US         200000
`define SWDT_TO5_US         800000
`define SWDT_TO6_US         1600000
`define SWDT_TO7_US         3200000
`define SWDT_SD0_US         25600000
`define SWDT_SD1_US         51200000
`define SWDT_SD2_US         102400000
`define SWDT_SD3_US         128000000
`define SWDT_CYC_PER_US     (`SWDT_CLK_HZ / 1000000)
`define SWDT_FLAG_CYC       3

`endif

// File: src/swdt_edge_det.v
`timescale 1ns/1ns
// detects either edge of the host activity input
module swdt_edge_det (
    // clock and reset
    input  wire clk,
    input  wire rst_b,
    // activity
    input  wire host_activity_in,
    output wire toggle_pulse
);
    reg last_q;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_q <= 1'b0;
        end else begin
            last_q <= host_activity_in;
        end
    end

    // the first sample after reset may look like a toggle; harmless, it only restarts a period
    assign toggle_pulse = last_q ^ host_activity_in;
endmodule // swdt_edge_det

// File: src/swdt_period_sel.v
`timescale 1ns/1ns
`include "swdt_consts.vh"
// maps configuration codes to cycle counts
module swdt_period_sel #(
    parameter CW = 32
) (
    // codes
    input  wire [2:0]    to_code,
    input  wire [1:0]    sd_code,
    // counts
    output reg  [CW-1:0] to_cycles,
    output reg  [CW-1:0] sd_cycles
);
    function [CW-1:0] us_to_cyc;
        input [31:0] us;
        begin
            us_to_cyc = us * `SWDT_CYC_PER_US;
        end
    endfunction

    always @* begin
        case (to_code)
            3'h0:    to_cycles = us_to_cyc(`SWDT_TO0_US);
            3'h1:    to_cycles = us_to_cyc(`SWDT_TO1_US);
            3'h2:    to_cycles = us_to_cyc(`SWDT_TO2_US);
            3'h3:    to_cycles = us_to_cyc(`SWDT_TO3_US);
            3'h4:    to_cycles = us_to_cyc(`SWDT_TO4_US);
            3'h5:    to_cycles = us_to_cyc(`SWDT_TO5_US);
            3'h6:    to_cycles = us_to_cyc(`SWDT_TO6_US);
            default: to_cycles = us_to_cyc(`SWDT_TO7_US);
        endcase
        case (sd_code)
            2'h0:    sd_cycles = us_to_cyc(`SWDT_SD0_US);
            2'h1:    sd_cycles = us_to_cyc(`SWDT_SD1_US);
            2'h2:    sd_cycles = us_to_cyc(`SWDT_SD2_US);
            default: sd_cycles = us_to_cyc(`SWDT_SD3_US);
        endcase
    end
endmodule // swdt_period_sel

// File: bench/swdt_assertions.sv
`timescale 1ns/1ns
module swdt_chk #(
    parameter RST_PULSE_CYC = 500
) (
    // clock and reset
    input wire       clk,
    input wire       rst_b,
    // register port
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire [7:0] reg_wdata,
    // system state
    input wire       independent_mode_select,
    input wire       seq_done,
    // host side
    input wire       host_activity_in,
    input wire       timeout_flag_out_n,
    input wire       wd_reset_out_n,
    input wire       wd_active,
    input wire       in_startup
);
    reg [7:0]  cfg_q;
    reg [31:0] low_q;
    // shadow of the config register, so checks need no hierarchical peeking
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= 8'h00;
            low_q <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == 8'h55)
                cfg_q <= reg_wdata;
            low_q <= wd_reset_out_n ? 32'h0 : low_q + 32'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    flag_width_a: assert property ($fell(timeout_flag_out_n) && cfg_q[7] |->
        !timeout_flag_out_n [*3] ##1 timeout_flag_out_n) else $error("flag width");
    reset_after_a: assert property ($fell(timeout_flag_out_n) && cfg_q[7] |=>
        !wd_reset_out_n) else $error("reset late");
    reset_spared_a: assert property ($fell(timeout_flag_out_n) && !cfg_q[7] |=>
        wd_reset_out_n) else $error("reset driven");
    reset_len_a: assert property ($rose(wd_reset_out_n) |-> low_q == RST_PULSE_CYC)
        else $error("reset length");
    enable_gate_a: assert property ($rose(wd_active) |-> $past(cfg_q[5]))
        else $error("started disabled");
    startup_sel_a: assert property ($rose(wd_active) |-> in_startup == $past(cfg_q[6]))
        else $error("startup choice");
    startup_end_a: assert property (in_startup && $changed(host_activity_in) |->
        ##[1:4] !in_startup) else $error("startup kept");
    toggle_clear_a: assert property (!timeout_flag_out_n && cfg_q[5] && !cfg_q[7] &&
        $changed(host_activity_in) |-> ##[1:4] timeout_flag_out_n) else $error("flag held");
    dep_hold_a: assert property ((!independent_mode_select && !seq_done) [*4] |->
        timeout_flag_out_n) else $error("dependent flag");
    off_quiet_a: assert property ((!cfg_q[5]) [*4] |-> timeout_flag_out_n && !in_startup)
        else $error("disabled busy");
    cover property ($fell(wd_reset_out_n));
    cover property ($fell(in_startup));
    cover property ($rose(timeout_flag_out_n));
endmodule // swdt_chk

bind swdt_top swdt_chk #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_swdt_chk (
    .clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .independent_mode_select, .seq_done,
    .host_activity_in, .timeout_flag_out_n, .wd_reset_out_n, .wd_active, .in_startup);

// File: bench/swdt_host_model.sv
`timescale 1ns/1ns
// host toggling its activity line every gap cycles while enabled
module swdt_host_model (
    // clock
    input wire        clk,
    // control
    input wire        en,
    input wire [15:0] gap,
    // activity
    output reg        host_activity_in
);
    reg [15:0] cnt_q = 16'h0;
    initial host_activity_in = 1'b0;
    always @(posedge clk) begin
        if (!en)
            cnt_q <= 16'h0;
        else if (cnt_q + 16'h1 >= gap) begin
            host_activity_in <= ~host_activity_in;
            cnt_q <= 16'h0;
        end else
            cnt_q <= cnt_q + 16'h1;
    end
endmodule // swdt_host_model

// File: bench/swdt_top_tb.sv
`timescale 1ns/1ns
`include "swdt_consts.vh"
module swdt_top_tb;
    localparam TS = 10000;
    localparam RP = 8;
    reg        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, imode = 1'b1, h_en = 1'b0;
    reg        boot = 1'b0, sdone = 1'b0, srst_n = 1'b0;
    reg  [7:0] addr = 8'h00, wdata = 8'h00;
    reg [15:0] h_gap = 16'h1;
    wire [7:0] rdata;
    wire       act, flag_n, rst_n, active, startup;
    integer    err_count = 0, total_checks = 0, cyc = 0, n, lim, i, el;
    // reference model: expected expiry counts queued from the rule table
    int        exp_q [$];
    int        tbl [8] = '{1000, 4000, 12500, 50000, 200000, 800000, 1600000, 3200000};
    swdt_top #(.TIME_SCALE(TS), .RST_PULSE_CYC(RP)) u_swdt_top (.clk(clk), .rst_b(rst_b),
        .reg_addr(addr), .reg_wr(reg_wr), .reg_wdata(wdata), .reg_rdata(rdata),
        .independent_mode_select(imode), .boot_done(boot), .seq_done(sdone),
        .seq_reset_n(srst_n), .host_activity_in(act), .timeout_flag_out_n(flag_n),
        .wd_reset_out_n(rst_n), .wd_active(active), .in_startup(startup));
    swdt_host_model u_swdt_host_model (.clk(clk), .en(h_en), .gap(h_gap),
        .host_activity_in(act));
    initial forever #25 clk = ~clk;
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input ok, input string m);
        total_checks++;
        if (!ok) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk);
        addr <= a;
        reg_wr <= 1'b1;
        wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1 chk(rdata === ((a == 8'h55) ? d : 8'h00), "readback");
    endtask
    // bounded wait, so a stuck flag cannot hang the run
    task waitf(input v, input integer mx);
        #1 n = 0;
        while (flag_n !== v && n < mx) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task tog;
        @(posedge clk);
        h_gap <= 16'h1;
        h_en <= 1'b1;
        @(posedge clk);
        h_en <= 1'b0;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_count++;
            $display("[FAIL] %0t timeout", $time);
            give_verdict;
        end
    end
    initial begin
        void'($urandom(32'h073D));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        wr(8'h55, 8'h20);
        repeat (20) @(posedge clk);
        #1 chk(flag_n === 1'b1, "boot gate");
        @(posedge clk);
        boot <= 1'b1;
        // sequencer held in reset: independent mode must not care
        for (i = 0; i < 8; i++) begin
            lim = tbl[i] * `SWDT_CYC_PER_US / TS;
            exp_q.push_back(lim);
            @(posedge clk);
            h_gap <= 16'h1 + 16'($urandom % (lim / 4 + 1));
            h_en <= 1'b1;
            wr(8'h55, 8'h20 | i[7:0]);
            repeat (3 * lim) @(posedge clk);
            #1 chk(flag_n === 1'b1, "early flag");
            @(posedge clk);
            h_en <= 1'b0;
            waitf(1'b0, lim + 8);
            el = exp_q.pop_front();
            chk(n >= el - h_gap && n <= el + 5, "period");
            tog();
            waitf(1'b1, 6);
            chk(flag_n === 1'b1, "toggle clear");
            $display("period code %0d done", i);
        end
        wr(8'h55, 8'h00);
        repeat (6) @(posedge clk);
        #1 chk(flag_n === 1'b1 && active === 1'b0, "disabled");
        wr(8'h55, 8'hE1);
        repeat (3) @(posedge clk);
        #1 chk(startup === 1'b1, "startup");
        tog();
        repeat (4) @(posedge clk);
        #1 chk(startup === 1'b0, "startup end");
        waitf(1'b0, 16);
        @(posedge clk);
        #1 chk(flag_n === 1'b0 && rst_n === 1'b0, "reset pulse");
        repeat (RP) @(posedge clk);
        #1 chk(rst_n === 1'b1 && flag_n === 1'b1, "reset end");
        $display("reset output test done");
        wr(8'h55, 8'h00);
        @(posedge clk);
        imode <= 1'b0;
        wr(8'h55, 8'h21);
        repeat (30) @(posedge clk);
        #1 chk(flag_n === 1'b1 && active === 1'b0, "dep hold");
        @(posedge clk);
        sdone <= 1'b1;
        srst_n <= 1'b1;
        waitf(1'b0, 20);
        chk(flag_n === 1'b0, "dep run");
        @(posedge clk);
        srst_n <= 1'b0;
        waitf(1'b1, 3);
        chk(flag_n === 1'b1, "dep clear");
        wr(8'h54, 8'hFF);
        @(posedge clk);
        addr <= 8'h55;
        #1 chk(rdata === 8'h21, "unmapped write");
        $display("dependent mode test done");
        give_verdict;
    end
endmodule // swdt_top_tb
